// [pkg/compare_buffer_defs.svh]
// Constants for the compare buffer transfer control pair.
// Behaviour
// - One 16-bit control register per channel pair.
// - Field 00 copies every write immediately.
// - Field 01 copies at zero point.
// - Field 10 copies at peak point.
// - Field 11 copies at zero or peak.
// - Linked 01 also needs zero mask count zero.
// - Linked 10 also needs peak mask count zero.
// - Linked 11 pairs each point with its count.
// - Four buffered registers, each own field and link.
// - Value fields change only with channels stopped.
// - Action fields change stopped; legacy keeps zero.
// - Extend bit widens the match test.
// - Extend bits only used in enhanced mode.
// - Extend bits unbuffered, changed only when stopped.
// - Pending action copies while timer stopped.
// - Action read returns active, not buffer.
// - Extended match: peak ge, zero le.
`ifndef COMPARE_BUFFER_DEFS_SVH
`define COMPARE_BUFFER_DEFS_SVH
`define CBT_ADDR_W 3
`define CBT_A_CTRL 3'h0
`define CBT_A_VAL0 3'h1
`define CBT_A_VAL1 3'h2
`define CBT_A_ACT0 3'h3
`define CBT_A_ACT1 3'h4
`define CBT_A_STAT 3'h5
`define CBT_F_VAL0 1:0
`define CBT_F_VAL1 3:2
`define CBT_F_ACT0 5:4
`define CBT_F_ACT1 7:6
`define CBT_B_LVAL0 8
`define CBT_B_LVAL1 9
`define CBT_B_LACT0 10
`define CBT_B_LACT1 11
`define CBT_B_EXT0 12
`define CBT_B_EXT1 13
`define CBT_CTRL_MASK 16'h3FFF
`define CBT_CTRL_RESET 16'h0000
`define CBT_X_NONE 2'h0
`define CBT_X_ZERO 2'h1
`define CBT_X_PEAK 2'h2
`define CBT_X_BOTH 2'h3
`define CBT_MASK_ZERO 4'h0
`endif

// [pkg/compare_buffer_pkg.sv]
// Types for the compare buffer transfer control pair.
package compare_buffer_pkg;
    typedef enum logic [2:0] {
        cmd_idle = 3'b001,
        cmd_write = 3'b010,
        cmd_read = 3'b100
    } cmd_state_t;
endpackage : compare_buffer_pkg

// [pkg/compare_buffer_if.sv]
// Register port between the pair control and its driving controller.
`timescale 1ns/1ps
interface compare_buffer_if;
    logic [2:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    modport dev (input addr, input wdata, input wr, input rd, output rdata);
    modport ctl (output addr, output wdata, output wr, output rd,
        input rdata);
endinterface : compare_buffer_if

// [rtl/compare_buffer_transfer_ctrl.sv]
// Buffer transfer control and match extension for one channel pair.
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "compare_buffer_defs.svh"
module compare_buffer_transfer_ctrl
    import compare_buffer_pkg::*;
#(
    parameter int VAL_W = 16,
    parameter int ACT_W = 16,
    parameter int MASK_W = 4
)
(
    input wire logic clk,
    input wire logic nrst,
    compare_buffer_if.dev bus,
    input wire logic at_zero,
    input wire logic at_peak,
    input wire logic timer_count_stop,
    input wire logic [MASK_W-1:0] zero_point_mask_count,
    input wire logic [MASK_W-1:0] peak_point_mask_count,
    input wire logic [VAL_W-1:0] timer_count,
    output logic [VAL_W-1:0] compare_value0,
    output logic [VAL_W-1:0] compare_value1,
    output logic [ACT_W-1:0] compare_action_setting0,
    output logic [ACT_W-1:0] compare_action_setting1,
    output logic [1:0] match
);
    // The read mux and the mask test are built for these widths only.
    if (VAL_W != 16 || ACT_W < 1 || ACT_W > 16 || MASK_W != 4)
    begin : g_bad_width
        $error("compare_buffer_transfer_ctrl: unsupported widths");
    end

    logic [15:0] ctrl, next_ctrl;
    logic [VAL_W-1:0] vbuf0, vbuf1, next_vbuf0, next_vbuf1;
    logic [ACT_W-1:0] abuf0, abuf1, next_abuf0, next_abuf1;
    logic [VAL_W-1:0] next_val0, next_val1;
    logic [ACT_W-1:0] next_act0, next_act1;
    logic [15:0] rdata, next_rdata;
    logic [1:0] next_match;
    logic [3:0] pend, next_pend;

    // Decides whether a buffered copy is due at this cycle.
    function automatic logic xfer_due(input logic [1:0] sel,
        input logic link, input logic z, input logic p,
        input logic zc_ok, input logic pc_ok);
        logic zt;
        logic pt;
        zt = z && (!link || zc_ok);
        pt = p && (!link || pc_ok);
        case (sel)
            `CBT_X_ZERO: xfer_due = zt;
            `CBT_X_PEAK: xfer_due = pt;
            `CBT_X_BOTH: xfer_due = zt || pt;
            default: xfer_due = 1'b0;
        endcase
    endfunction : xfer_due

    // Plain or widened match of one channel.
    function automatic logic match_of(input logic [VAL_W-1:0] cv,
        input logic [VAL_W-1:0] cnt, input logic ext,
        input logic z, input logic p);
        match_of = (cv == cnt)
            || (ext && p && cv >= cnt)
            || (ext && z && cv <= cnt);
    endfunction : match_of

    logic zc_ok, pc_ok;
    logic [3:0] due;
    assign zc_ok = zero_point_mask_count == `CBT_MASK_ZERO;
    assign pc_ok = peak_point_mask_count == `CBT_MASK_ZERO;
    assign due[0] = xfer_due(ctrl[`CBT_F_VAL0], ctrl[`CBT_B_LVAL0],
        at_zero, at_peak, zc_ok, pc_ok);
    assign due[1] = xfer_due(ctrl[`CBT_F_VAL1], ctrl[`CBT_B_LVAL1],
        at_zero, at_peak, zc_ok, pc_ok);
    assign due[2] = xfer_due(ctrl[`CBT_F_ACT0], ctrl[`CBT_B_LACT0],
        at_zero, at_peak, zc_ok, pc_ok);
    assign due[3] = xfer_due(ctrl[`CBT_F_ACT1], ctrl[`CBT_B_LACT1],
        at_zero, at_peak, zc_ok, pc_ok);

    always_comb
    begin
        next_ctrl = ctrl;
        next_vbuf0 = vbuf0;
        next_vbuf1 = vbuf1;
        next_abuf0 = abuf0;
        next_abuf1 = abuf1;
        next_val0 = compare_value0;
        next_val1 = compare_value1;
        next_act0 = compare_action_setting0;
        next_act1 = compare_action_setting1;
        next_pend = pend;
        next_rdata = 16'h0000;
        // Buffered copies take the buffer as it stood before this write.
        if (due[0])
            next_val0 = vbuf0;
        if (due[1])
            next_val1 = vbuf1;
        if (due[2] || (pend[2] && timer_count_stop))
        begin
            next_act0 = abuf0;
            next_pend[2] = 1'b0;
        end
        if (due[3] || (pend[3] && timer_count_stop))
        begin
            next_act1 = abuf1;
            next_pend[3] = 1'b0;
        end
        if (bus.wr)
        begin
            if (bus.addr == `CBT_A_CTRL)
                next_ctrl = bus.wdata & `CBT_CTRL_MASK;
            else if (bus.addr == `CBT_A_VAL0)
            begin
                next_vbuf0 = bus.wdata[VAL_W-1:0];
                if (ctrl[`CBT_F_VAL0] == `CBT_X_NONE)
                    next_val0 = bus.wdata[VAL_W-1:0];
            end
            else if (bus.addr == `CBT_A_VAL1)
            begin
                next_vbuf1 = bus.wdata[VAL_W-1:0];
                if (ctrl[`CBT_F_VAL1] == `CBT_X_NONE)
                    next_val1 = bus.wdata[VAL_W-1:0];
            end
            else if (bus.addr == `CBT_A_ACT0)
            begin
                next_abuf0 = bus.wdata[ACT_W-1:0];
                next_pend[2] = 1'b1;
                if (ctrl[`CBT_F_ACT0] == `CBT_X_NONE)
                begin
                    next_act0 = bus.wdata[ACT_W-1:0];
                    next_pend[2] = 1'b0;
                end
            end
            else if (bus.addr == `CBT_A_ACT1)
            begin
                next_abuf1 = bus.wdata[ACT_W-1:0];
                next_pend[3] = 1'b1;
                if (ctrl[`CBT_F_ACT1] == `CBT_X_NONE)
                begin
                    next_act1 = bus.wdata[ACT_W-1:0];
                    next_pend[3] = 1'b0;
                end
            end
        end
        if (bus.rd)
        begin
            if (bus.addr == `CBT_A_CTRL)
                next_rdata = ctrl;
            else if (bus.addr == `CBT_A_VAL0)
                next_rdata = compare_value0;
            else if (bus.addr == `CBT_A_VAL1)
                next_rdata = compare_value1;
            else if (bus.addr == `CBT_A_ACT0)
                next_rdata = 16'(compare_action_setting0);
            else if (bus.addr == `CBT_A_ACT1)
                next_rdata = 16'(compare_action_setting1);
            else if (bus.addr == `CBT_A_STAT)
                next_rdata = {12'h000, pend[3:2], match};
            else
                next_rdata = 16'h0000;
        end
        next_match[0] = match_of(compare_value0, timer_count,
            ctrl[`CBT_B_EXT0], at_zero, at_peak);
        next_match[1] = match_of(compare_value1, timer_count,
            ctrl[`CBT_B_EXT1], at_zero, at_peak);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl <= `CBT_CTRL_RESET;
            vbuf0 <= '0;
            vbuf1 <= '0;
            abuf0 <= '0;
            abuf1 <= '0;
            compare_value0 <= '0;
            compare_value1 <= '0;
            compare_action_setting0 <= '0;
            compare_action_setting1 <= '0;
            pend <= 4'h0;
            rdata <= 16'h0000;
            match <= 2'h0;
        end
        else
        begin
            ctrl <= next_ctrl;
            vbuf0 <= next_vbuf0;
            vbuf1 <= next_vbuf1;
            abuf0 <= next_abuf0;
            abuf1 <= next_abuf1;
            compare_value0 <= next_val0;
            compare_value1 <= next_val1;
            compare_action_setting0 <= next_act0;
            compare_action_setting1 <= next_act1;
            pend <= next_pend;
            rdata <= next_rdata;
            match <= next_match;
        end
    end

    assign bus.rdata = rdata;
endmodule : compare_buffer_transfer_ctrl

// [rtl/compare_buffer_controller.sv]
// Software-side controller that keeps the change-while-stopped discipline.
`timescale 1ns/1ps
`include "compare_buffer_defs.svh"
module compare_buffer_controller
    import compare_buffer_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    compare_buffer_if.ctl bus,
    input wire logic req_wr,
    input wire logic req_rd,
    input wire logic [2:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic channel0_run,
    input wire logic channel1_run,
    input wire logic enhanced_mode_select,
    output logic [15:0] resp_rdata,
    output logic resp_valid,
    output logic req_refused
);
    cmd_state_t state, next_state;
    logic [2:0] addr, next_addr;
    logic [15:0] wdata, next_wdata;
    logic wr, next_wr, rd, next_rd;
    logic [15:0] next_resp;
    logic next_valid, next_refused;
    logic [15:0] clean;

    always_comb
    begin
        clean = req_wdata & `CBT_CTRL_MASK;
        if (!enhanced_mode_select)
        begin
            clean[`CBT_F_ACT0] = `CBT_X_NONE;
            clean[`CBT_F_ACT1] = `CBT_X_NONE;
            clean[`CBT_B_LACT0] = 1'b0;
            clean[`CBT_B_LACT1] = 1'b0;
            clean[`CBT_B_EXT0] = 1'b0;
            clean[`CBT_B_EXT1] = 1'b0;
        end
        next_state = cmd_idle;
        next_addr = addr;
        next_wdata = wdata;
        next_wr = 1'b0;
        next_rd = 1'b0;
        next_resp = resp_rdata;
        next_valid = 1'b0;
        next_refused = 1'b0;
        case (state)
            cmd_read:
            begin
                next_resp = bus.rdata;
                next_valid = 1'b1;
            end
            default:
            begin
            end
        endcase
        if (req_wr)
        begin
            next_addr = req_addr;
            if (req_addr == `CBT_A_CTRL)
            begin
                next_wdata = clean;
                if (channel0_run || channel1_run)
                    next_refused = 1'b1;
                else
                begin
                    next_wr = 1'b1;
                    next_state = cmd_write;
                end
            end
            else
            begin
                next_wdata = req_wdata;
                next_wr = 1'b1;
                next_state = cmd_write;
            end
        end
        else if (req_rd)
        begin
            next_addr = req_addr;
            next_rd = 1'b1;
            next_state = cmd_read;
        end
    end

    // The read answer is taken one cycle after the device strobe.
    cmd_state_t rd_stage;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= cmd_idle;
            rd_stage <= cmd_idle;
            addr <= 3'h0;
            wdata <= 16'h0000;
            wr <= 1'b0;
            rd <= 1'b0;
            resp_rdata <= 16'h0000;
            resp_valid <= 1'b0;
            req_refused <= 1'b0;
        end
        else
        begin
            state <= rd_stage;
            rd_stage <= next_state;
            addr <= next_addr;
            wdata <= next_wdata;
            wr <= next_wr;
            rd <= next_rd;
            resp_rdata <= next_resp;
            resp_valid <= next_valid;
            req_refused <= next_refused;
        end
    end

    assign bus.addr = addr;
    assign bus.wdata = wdata;
    assign bus.wr = wr;
    assign bus.rd = rd;
endmodule : compare_buffer_controller

// [tb/compare_buffer_properties.sv]
// Concurrent checks on the register port and channel 0 active registers.
`timescale 1ns/1ps
module compare_buffer_properties
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    input wire logic at_zero,
    input wire logic at_peak,
    input wire logic [3:0] zero_point_mask_count,
    input wire logic [3:0] peak_point_mask_count,
    input wire logic [15:0] compare_value0,
    input wire logic [15:0] compare_action_setting0
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Shadow of the control word as it crosses the port; refused writes
    // never reach the port, so no run-bit tracking is needed here.
    logic [15:0] ctrl;
    logic [15:0] next_ctrl;
    always_comb
    begin
        next_ctrl = ctrl;
        if (wr && addr == 3'h0)
            next_ctrl = wdata & 16'h3FFF;
    end
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ctrl <= 16'h0000;
        else
            ctrl <= next_ctrl;
    end
    property p_one_strobe; !(wr && rd); endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("wr with rd");
    property p_idle_rdata; !rd |=> rdata == 16'h0000; endproperty
    a_idle_rdata: assert property (p_idle_rdata) else $error("idle rdata");
    property p_unmapped; rd && addr > 3'h5 |=> rdata == 16'h0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_ctrl_read; rd && addr == 3'h0 |=> rdata == $past(ctrl);
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("ctrl read");
    property p_direct;
        wr && addr == 3'h1 && ctrl[1:0] == 2'h0 |=>
            compare_value0 == $past(wdata);
    endproperty
    a_direct: assert property (p_direct) else $error("direct copy");
    property p_timed;
        $changed(compare_value0) && $past(ctrl[1:0]) != 2'h0 &&
            !$past(ctrl[8]) |-> $past(ctrl[0] && at_zero || ctrl[1] && at_peak);
    endproperty
    a_timed: assert property (p_timed) else $error("timed copy");
    property p_linked;
        $changed(compare_value0) && $past(ctrl[1:0]) != 2'h0 && $past(ctrl[8])
            |-> $past(ctrl[0] && at_zero && zero_point_mask_count == 4'h0 ||
            ctrl[1] && at_peak && peak_point_mask_count == 4'h0);
    endproperty
    a_linked: assert property (p_linked) else $error("linked copy");
    property p_act_read;
        rd && addr == 3'h3 |=> rdata == $past(compare_action_setting0);
    endproperty
    a_act_read: assert property (p_act_read) else $error("act read");
    c_direct: cover property (wr && addr == 3'h1);
    c_zero: cover property (at_zero && ctrl[1:0] == 2'h1);
    c_act_read: cover property (rd && addr == 3'h3);
endmodule : compare_buffer_properties

// [tb/compare_buffer_transfer_ctrl_test.sv]
// Bench joining the controller and the pair control across the port.
`timescale 1ns/1ps
module compare_buffer_transfer_ctrl_test;
    logic clk = 1'b0, nrst = 1'b0, req_wr = 1'b0, req_rd = 1'b0;
    logic run0 = 1'b0, enh = 1'b1, at_zero = 1'b0, at_peak = 1'b0;
    logic stop = 1'b0, resp_valid, req_refused, refused_seen = 1'b0;
    logic run1 = 1'b0;
    logic [2:0] req_addr = 3'h0;
    logic [3:0] zmc = 4'h0, pmc = 4'h0;
    logic [15:0] req_wdata = 16'h0000, cnt = 16'h0000, act;
    logic [15:0] cv0, cv1, ca0, ca1, resp_rdata;
    logic [1:0] match;
    int err_total = 0, tests_run = 0;
    always #4 clk = ~clk;
    compare_buffer_if bus_if();
    compare_buffer_transfer_ctrl i_compare_buffer_transfer_ctrl (.clk(clk),
        .nrst(nrst), .bus(bus_if), .at_zero(at_zero), .at_peak(at_peak),
        .timer_count_stop(stop), .zero_point_mask_count(zmc),
        .peak_point_mask_count(pmc), .timer_count(cnt),
        .compare_value0(cv0), .compare_value1(cv1),
        .compare_action_setting0(ca0), .compare_action_setting1(ca1),
        .match(match));
    compare_buffer_controller i_compare_buffer_controller (.clk(clk),
        .nrst(nrst), .bus(bus_if), .req_wr(req_wr), .req_rd(req_rd),
        .req_addr(req_addr), .req_wdata(req_wdata), .channel0_run(run0),
        .channel1_run(run1), .enhanced_mode_select(enh),
        .resp_rdata(resp_rdata), .resp_valid(resp_valid),
        .req_refused(req_refused));
    compare_buffer_properties i_compare_buffer_properties (.clk(clk),
        .nrst(nrst), .addr(bus_if.addr), .wdata(bus_if.wdata),
        .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata),
        .at_zero(at_zero), .at_peak(at_peak), .zero_point_mask_count(zmc),
        .peak_point_mask_count(pmc), .compare_value0(cv0),
        .compare_action_setting0(ca0));
    // The refusal is a one-cycle pulse, so it is latched for a later look.
    always @(posedge clk)
        if (req_refused === 1'b1)
            refused_seen <= 1'b1;
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // The wr_reg, rd_reg and pulse tasks end at a falling edge so that outputs are settled.
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        req_wr <= 1'b1;
        req_addr <= a;
        req_wdata <= d;
        @(posedge clk);
        req_wr <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask : wr_reg
    task automatic rd_reg(input logic [2:0] a, input logic [15:0] exp);
        int n;
        @(posedge clk);
        req_rd <= 1'b1;
        req_addr <= a;
        @(posedge clk);
        req_rd <= 1'b0;
        for (n = 0; n < 8 && resp_valid !== 1'b1; n++)
            @(negedge clk);
        check({15'h0000, resp_valid}, 16'h0001);
        check(resp_rdata, exp);
    endtask : rd_reg
    task automatic pulse(input logic z, input logic p);
        @(posedge clk);
        at_zero <= z;
        at_peak <= p;
        @(posedge clk);
        at_zero <= 1'b0;
        at_peak <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : pulse
    task automatic final_report();
        $display("tests_run=%0d err_total=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report
    initial
    begin
        #20000;
        err_total++;
        final_report();
    end
    initial
    begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(3'h0, 16'h0000);
        rd_reg(3'h3, 16'h0000);
        rd_reg(3'h7, 16'h0000);
        $display("test reset values done");
        wr_reg(3'h1, 16'h1234);
        check(cv0, 16'h1234);
        act = 16'h1234;
        for (int s = 1; s < 4; s++)
        begin
            wr_reg(3'h0, 16'(s));
            wr_reg(3'h1, 16'h0A00 + 16'(s));
            check(cv0, act);
            pulse(1'b0, 1'b1);
            if (s[1])
                act = 16'h0A00 + 16'(s);
            check(cv0, act);
            pulse(1'b1, 1'b0);
            if (s[0])
                act = 16'h0A00 + 16'(s);
            check(cv0, act);
        end
        $display("test timed copy done");
        wr_reg(3'h0, 16'h0103);
        @(posedge clk);
        zmc <= 4'h1;
        pmc <= 4'h2;
        wr_reg(3'h1, 16'h0B00);
        pulse(1'b1, 1'b1);
        check(cv0, act);
        @(posedge clk);
        zmc <= 4'h0;
        pulse(1'b1, 1'b0);
        check(cv0, 16'h0B00);
        $display("test linked copy done");
        wr_reg(3'h0, 16'h0010);
        wr_reg(3'h3, 16'h00C3);
        rd_reg(3'h3, 16'h0000);
        @(posedge clk);
        stop <= 1'b1;
        repeat (2) @(posedge clk);
        stop <= 1'b0;
        @(negedge clk);
        check(ca0, 16'h00C3);
        $display("test action buffer done");
        wr_reg(3'h0, 16'h0008);
        wr_reg(3'h2, 16'h0222);
        wr_reg(3'h4, 16'h0044);
        check(cv1, 16'h0000);
        check(ca1, 16'h0044);
        pulse(1'b0, 1'b1);
        check(cv1, 16'h0222);
        $display("test channel one done");
        wr_reg(3'h0, 16'h1000);
        wr_reg(3'h1, 16'h0010);
        @(posedge clk);
        cnt <= 16'h0008;
        at_peak <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check({15'h0000, match[0]}, 16'h0001);
        rd_reg(3'h5, 16'h0001);
        wr_reg(3'h0, 16'h0000);
        check({15'h0000, match[0]}, 16'h0000);
        $display("test extend done");
        @(posedge clk);
        at_peak <= 1'b0;
        run0 <= 1'b1;
        wr_reg(3'h0, 16'h0003);
        check({15'h0000, refused_seen}, 16'h0001);
        rd_reg(3'h0, 16'h0000);
        @(posedge clk);
        run0 <= 1'b0;
        run1 <= 1'b1;
        wr_reg(3'h0, 16'h0003);
        rd_reg(3'h0, 16'h0000);
        @(posedge clk);
        run1 <= 1'b0;
        enh <= 1'b0;
        wr_reg(3'h0, 16'h3FFF);
        rd_reg(3'h0, 16'h030F);
        $display("test refusal and legacy done");
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(3'h0, 16'h0000);
        check(cv0, 16'h0000);
        $display("test second reset done");
        final_report();
    end
endmodule : compare_buffer_transfer_ctrl_test
